// *** rtl/scx_pkg.sv ***
// shared constants and types for the sixteen-bit compare execution block
package scx_pkg;
  // opcode and prefix bytes
  localparam logic [7:0] PFX_ACC = 8'h1a;    // prefix for the double-accumulator compare
  localparam logic [7:0] PFX_Y = 8'hcd;      // prefix for the second-index forms
  localparam logic [7:0] OPD_IMMEDIATE = 8'h83; // double-accumulator compare, immediate
  localparam logic [7:0] OPD_DIR = 8'h93;    // double-accumulator compare, direct
  localparam logic [7:0] OPD_EXTENDED = 8'hb3; // double-accumulator compare, extended
  localparam logic [7:0] OPD_IDX = 8'ha3;    // double-accumulator compare, indexed
  localparam logic [7:0] OPX_IMMEDIATE = 8'h8c; // index-x compare, immediate
  localparam logic [7:0] OPX_DIR = 8'h9c;    // index-x compare, direct
  localparam logic [7:0] OPX_EXTENDED = 8'hbc; // index-x compare, extended
  localparam logic [7:0] OPX_IDX = 8'hac;    // index-x compare, indexed
  localparam logic [15:0] DUMMY_ADDR = 16'hffff; // address of every dummy read
  localparam logic [15:0] ONE16 = 16'h0001;  // word increment
  localparam logic [7:0] ZERO8 = 8'h00;      // direct-page high byte
  localparam int MSB = 15;                   // sign bit of a word

  // addressing modes
  typedef enum logic [2:0] {
    MODE_IMMEDIATE,
    MODE_DIR,
    MODE_EXTENDED,
    MODE_IDX,
    MODE_IDY
  } scx_mode_type;

  // condition code results of one compare
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } scx_flags_type;

  // one decoded instruction
  typedef struct packed {
    logic valid;            // byte pair names a compare
    logic use_x;            // index-x compare rather than double accumulator
    scx_mode_type mode;     // addressing mode
  } scx_dec_type;
endpackage

// *** rtl/scx_flags.sv ***
// flag logic of a discarded sixteen-bit subtraction
module scx_flags (
  input wire logic [15:0] reg_i,
  input wire logic [15:0] mem_i,
  output scx_pkg::scx_flags_type flags_o
);
  // difference only; neither operand is written anywhere
  logic [15:0] diff;
  logic rs;
  logic ms;
  logic ds;

  // flags from the sign bits and the difference
  always_comb
  begin
    diff = reg_i - mem_i;
    rs = reg_i[scx_pkg::MSB];
    ms = mem_i[scx_pkg::MSB];
    ds = diff[scx_pkg::MSB];
    flags_o.n = ds;
    flags_o.z = (diff == 16'h0000);
    flags_o.v = (rs & ~ms & ~ds) | (~rs & ms & ds);
    flags_o.c = (~rs & ms) | (ms & ds) | (ds & ~rs);
  end
endmodule

// *** rtl/scx_exec.sv ***
// sequencer for the sixteen-bit compare instructions
// Notes on behaviour
// - operand high at address, low at next
// - accumulator compare only sets flags
// - index compare only sets flags
// - negative equals difference bit fifteen
// - zero set when difference is zero
// - overflow on signed subtraction overflow
// - carry on unsigned borrow
// - accumulator compare opcodes and prefixes
// - index compare opcodes and prefix
// - all reads; dummy reads at top address
module scx_exec (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,           // cycle 1: first opcode byte is on the bus now
  input wire logic [15:0] pc_i,       // address of the first opcode byte
  input wire logic [7:0] data_i,      // read data for the address driven this cycle
  input wire logic [15:0] double_accumulator_i,
  input wire logic [15:0] first_index_register_i,
  input wire logic [15:0] second_index_register_i,
  input wire logic [7:0] ccr_i,       // condition codes before the instruction
  output logic [15:0] addr_o,         // bus address of the current read
  output logic rnw_o,                 // always read
  output logic busy_o,                // a compare is in progress
  output logic done_o,                // pulse in the last cycle, ccr_o valid
  output logic illegal_o,             // pulse: byte pair is not a compare
  output logic [7:0] ccr_o            // updated condition codes
);
  // bus sequence steps
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OP2,
    ST_ARG1,
    ST_ARG2,
    ST_IDXD,
    ST_HI,
    ST_LO,
    ST_END
  } scx_step_type;

  // decode of prefix plus opcode into instruction and mode
  function automatic scx_pkg::scx_dec_type decode(input logic [7:0] pfx,
                                                   input logic [7:0] op);
    scx_pkg::scx_dec_type d;
    d = '{valid: 1'b1, use_x: 1'b0, mode: scx_pkg::MODE_IMMEDIATE};
    if (pfx == scx_pkg::PFX_ACC)
    begin
      case (op)
        scx_pkg::OPD_IMMEDIATE: d.mode = scx_pkg::MODE_IMMEDIATE;
        scx_pkg::OPD_DIR: d.mode = scx_pkg::MODE_DIR;
        scx_pkg::OPD_EXTENDED: d.mode = scx_pkg::MODE_EXTENDED;
        scx_pkg::OPD_IDX: d.mode = scx_pkg::MODE_IDX;
        default: d.valid = 1'b0;
      endcase
    end
    else if (pfx == scx_pkg::PFX_Y)
    begin
      d.mode = scx_pkg::MODE_IDY;
      if (op == scx_pkg::OPX_IDX)
        d.use_x = 1'b1;
      else if (op != scx_pkg::OPD_IDX)
        d.valid = 1'b0;
    end
    else
      d.valid = 1'b0;
    return d;
  endfunction

  // decode of an unprefixed single opcode (index-x compare)
  function automatic scx_pkg::scx_dec_type decode_x(input logic [7:0] op);
    scx_pkg::scx_dec_type d;
    d = '{valid: 1'b1, use_x: 1'b1, mode: scx_pkg::MODE_IMMEDIATE};
    case (op)
      scx_pkg::OPX_IMMEDIATE: d.mode = scx_pkg::MODE_IMMEDIATE;
      scx_pkg::OPX_DIR: d.mode = scx_pkg::MODE_DIR;
      scx_pkg::OPX_EXTENDED: d.mode = scx_pkg::MODE_EXTENDED;
      scx_pkg::OPX_IDX: d.mode = scx_pkg::MODE_IDX;
      default: d.valid = 1'b0;
    endcase
    return d;
  endfunction

  // state registers
  scx_step_type step_r, step_nxt;          // current bus step
  scx_pkg::scx_dec_type dec_r, dec_nxt;    // decoded instruction
  logic [7:0] pfx_r, pfx_nxt;              // first opcode byte
  logic [15:0] pc_r, pc_nxt;               // next instruction-stream address
  logic [15:0] ea_r, ea_nxt;               // effective address being built
  logic [7:0] hi_r, hi_nxt;                // operand high byte
  logic [7:0] ccr_r, ccr_nxt;              // condition code output
  logic ill_r, ill_nxt;                    // illegal opcode marker
  logic [15:0] addr_c;                     // address for this cycle
  logic [15:0] word_c;                     // assembled operand
  logic [15:0] regv_c;                     // register side of the compare
  scx_pkg::scx_flags_type fl_c;            // flag results
  scx_pkg::scx_dec_type dx_c;              // decode of start byte alone

  // the subtraction; result goes to flags only, nothing is written back
  always_comb
  begin
    word_c = {hi_r, data_i};
    regv_c = dec_r.use_x ? first_index_register_i : double_accumulator_i;
  end

  scx_flags u_flags (
    .reg_i(regv_c),
    .mem_i(word_c),
    .flags_o(fl_c)
  );

  // bus address multiplexer; every cycle is a read
  always_comb
  begin
    case (step_r)
      ST_IDLE: addr_c = pc_i;
      ST_OP2, ST_ARG1, ST_ARG2: addr_c = pc_r;
      ST_IDXD, ST_END: addr_c = scx_pkg::DUMMY_ADDR;
      ST_HI: addr_c = ea_r;
      ST_LO: addr_c = ea_r + scx_pkg::ONE16;
      default: addr_c = scx_pkg::DUMMY_ADDR;
    endcase
  end

  assign dx_c = decode_x(data_i);

  // next-state logic of the sequencer
  always_comb
  begin
    step_nxt = step_r;
    dec_nxt = dec_r;
    pfx_nxt = pfx_r;
    pc_nxt = pc_r;
    ea_nxt = ea_r;
    hi_nxt = hi_r;
    ccr_nxt = ccr_r;
    ill_nxt = 1'b0;
    case (step_r)
      ST_IDLE:
      begin
        if (start_i)
        begin
          pc_nxt = pc_i + scx_pkg::ONE16;
          pfx_nxt = data_i;
          if (data_i == scx_pkg::PFX_ACC || data_i == scx_pkg::PFX_Y)
            step_nxt = ST_OP2;
          else if (dx_c.valid)
          begin
            dec_nxt = dx_c;
            // immediate operand sits in the stream: its address is the effective one
            ea_nxt = pc_nxt;
            step_nxt = (dx_c.mode == scx_pkg::MODE_IMMEDIATE) ? ST_HI : ST_ARG1;
          end
          else
            ill_nxt = 1'b1;
        end
      end
      ST_OP2:
      begin
        dec_nxt = decode(pfx_r, data_i);
        pc_nxt = pc_r + scx_pkg::ONE16;
        ea_nxt = pc_nxt;
        if (!dec_nxt.valid)
        begin
          ill_nxt = 1'b1;
          step_nxt = ST_IDLE;
        end
        else
          step_nxt = (dec_nxt.mode == scx_pkg::MODE_IMMEDIATE) ? ST_HI : ST_ARG1;
      end
      ST_ARG1:
      begin
        pc_nxt = pc_r + scx_pkg::ONE16;
        case (dec_r.mode)
          scx_pkg::MODE_DIR:
          begin
            ea_nxt = {scx_pkg::ZERO8, data_i};
            step_nxt = ST_HI;
          end
          scx_pkg::MODE_EXTENDED:
          begin
            hi_nxt = data_i;
            step_nxt = ST_ARG2;
          end
          scx_pkg::MODE_IDX:
          begin
            ea_nxt = first_index_register_i + {scx_pkg::ZERO8, data_i};
            step_nxt = ST_IDXD;
          end
          scx_pkg::MODE_IDY:
          begin
            ea_nxt = second_index_register_i + {scx_pkg::ZERO8, data_i};
            step_nxt = ST_IDXD;
          end
          default: step_nxt = ST_IDLE;
        endcase
      end
      ST_ARG2:
      begin
        pc_nxt = pc_r + scx_pkg::ONE16;
        ea_nxt = {hi_r, data_i};
        step_nxt = ST_HI;
      end
      ST_IDXD: step_nxt = ST_HI;
      ST_HI:
      begin
        hi_nxt = data_i;
        step_nxt = ST_LO;
      end
      ST_LO:
      begin
        // keep s, x, h, i; replace n, z, v, c
        ccr_nxt = {ccr_i[7:4], fl_c.n, fl_c.z, fl_c.v, fl_c.c};
        step_nxt = ST_END;
      end
      ST_END:
      begin
        step_nxt = ST_IDLE;
      end
      default: step_nxt = ST_IDLE;
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      step_r <= ST_IDLE;
      dec_r <= '0;
      pfx_r <= 8'h00;
      pc_r <= 16'h0000;
      ea_r <= 16'h0000;
      hi_r <= 8'h00;
      ccr_r <= 8'h00;
      ill_r <= 1'b0;
    end
    else
    begin
      step_r <= step_nxt;
      dec_r <= dec_nxt;
      pfx_r <= pfx_nxt;
      pc_r <= pc_nxt;
      ea_r <= ea_nxt;
      hi_r <= hi_nxt;
      ccr_r <= ccr_nxt;
      ill_r <= ill_nxt;
    end
  end

  // outputs; done marks the final dummy read
  assign addr_o = addr_c;
  assign rnw_o = 1'b1;
  assign busy_o = (step_r != ST_IDLE);
  assign done_o = (step_r == ST_END);
  assign illegal_o = ill_r;
  assign ccr_o = ccr_r;

  // reference difference for the flag checks, worked out apart from the flag module
  logic [15:0] ref_diff;
  assign ref_diff = regv_c - word_c;

  // cycle number of the current step; the start cycle is 1, so the step after idle is 2
  logic [3:0] cyc_r;
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      cyc_r <= 4'h0;
    else if (step_r == ST_IDLE)
      cyc_r <= 4'h2;
    else
      cyc_r <= cyc_r + 4'h1;
  end

  chk_read_only: assert property (@(posedge clk_i) disable iff (!nrst_i) rnw_o)
    else $error("bus cycle not a read");
  chk_end_dummy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_END |-> addr_o == scx_pkg::DUMMY_ADDR)
    else $error("final cycle not a dummy read");
  chk_low_addr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_HI |=> addr_o == $past(addr_o) + scx_pkg::ONE16)
    else $error("low byte not at next address");
  chk_zero_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_LO |=> ccr_o[2] == ($past(regv_c) == $past(word_c)))
    else $error("zero flag wrong");
  chk_neg_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_LO |=> ccr_o[3] == $past(ref_diff[scx_pkg::MSB]))
    else $error("negative flag wrong");
  chk_ovf_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_LO |=> ccr_o[1] ==
      (($past(regv_c[scx_pkg::MSB]) ^ $past(word_c[scx_pkg::MSB]))
      & ($past(ref_diff[scx_pkg::MSB]) ^ $past(regv_c[scx_pkg::MSB]))))
    else $error("overflow flag wrong");
  chk_carry_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_LO |=> ccr_o[0] == ($past(word_c) > $past(regv_c)))
    else $error("carry flag wrong");
  chk_upper_kept: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_LO |=> ccr_o[7:4] == $past(ccr_i[7:4]))
    else $error("upper flags changed");
  chk_cycle_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    done_o |-> cyc_r == (dec_r.mode == scx_pkg::MODE_IDY ? 4'h7 :
                         dec_r.mode == scx_pkg::MODE_IMMEDIATE ? (dec_r.use_x ? 4'h4 : 4'h5) :
                         dec_r.mode == scx_pkg::MODE_DIR ? (dec_r.use_x ? 4'h5 : 4'h6) :
                         (dec_r.use_x ? 4'h6 : 4'h7)))
    else $error("instruction length wrong");
  chk_idx_dummy: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step_r == ST_ARG1 && (dec_r.mode == scx_pkg::MODE_IDX || dec_r.mode == scx_pkg::MODE_IDY)
    |=> addr_o == scx_pkg::DUMMY_ADDR ##1 step_r == ST_HI)
    else $error("indexed dummy read missing");

  cov_immediate: cover property (@(posedge clk_i)
    done_o && dec_r.mode == scx_pkg::MODE_IMMEDIATE);
  cov_idy: cover property (@(posedge clk_i) done_o && dec_r.mode == scx_pkg::MODE_IDY);
  cov_carry: cover property (@(posedge clk_i) step_r == ST_LO && fl_c.c);
  cov_illegal: cover property (@(posedge clk_i) illegal_o);
endmodule

// *** bench/scx_mem_model.sv ***
// behavioural memory that answers the compare sequencer's read bus
module scx_mem_model (
  input wire logic [15:0] addr_i,
  input wire logic rnw_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535]; // byte store, loaded by the bench
  // fill with an address-derived pattern so stale or wrong reads look like zero only where the low address byte is a5
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'ha5;
  end
  // same-cycle answer; a write request sees a pattern instead of memory contents
  // a continuous assignment so that a byte rewritten under a steady address shows at once
  assign data_o = rnw_i ? mem[addr_i] : ~addr_i[7:0];
endmodule

// *** bench/sixteen_bit_compare_exec_bench.sv ***
// self-checking bench for the sixteen-bit compare sequencer
`define CHK(got, exp, what) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("unexpected at %0t: %s", $time, what); \
    end \
  end
module sixteen_bit_compare_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, nrst_i, start_i, rnw_o, busy_o, done_o, illegal_o;
  logic [15:0] pc_i, addr_o, acc_i, x_i, y_i;
  logic [7:0] data_i, ccr_i, ccr_o;
  int err_total, num_checks;
  logic [15:0] exp_addr [$]; // expected address of every bus cycle
  scx_exec scx_exec_i (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .pc_i(pc_i),
    .data_i(data_i), .double_accumulator_i(acc_i), .first_index_register_i(x_i),
    .second_index_register_i(y_i), .ccr_i(ccr_i), .addr_o(addr_o), .rnw_o(rnw_o),
    .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .ccr_o(ccr_o));
  scx_mem_model scx_mem_model_i (.addr_i(addr_o), .rnw_i(rnw_o), .data_o(data_i));
  // 20 MHz core clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    scx_mem_model_i.mem[a] = d;
  endtask
  // one compare: builds the program, walks every bus cycle, checks flags at done
  task automatic run_cmp(input logic use_x, input int md, input logic [15:0] r,
    input logic [15:0] m, input logic hold_start);
    logic [15:0] op, a, ea, d;
    logic [7:0] opc;
    logic [7:0] fx;
    logic p;
    op = 16'h2000;
    p = !use_x || md == 4;
    acc_i = use_x ? ~r : r; // the unused register holds the inverse to expose mis-selection
    x_i = use_x ? r : ~r;
    y_i = 16'h5100;
    ccr_i = {r[3:0], 4'h6};
    opc = use_x ? 8'h8c : 8'h83;
    opc = opc | (md == 1 ? 8'h10 : md == 2 ? 8'h30 : md >= 3 ? 8'h20 : 8'h00);
    exp_addr = {op};
    if (p)
    begin
      put(op, md == 4 ? 8'hcd : 8'h1a);
      put(op + 16'h0001, opc);
      exp_addr.push_back(op + 16'h0001);
    end
    else
      put(op, opc);
    a = op + 16'h0001 + 16'(p);
    case (md)
      0: ea = a;
      1:
      begin
        put(a, 8'h40);
        exp_addr.push_back(a);
        ea = 16'h0040;
      end
      2:
      begin
        put(a, 8'h34);
        put(a + 16'h0001, 8'h56);
        exp_addr.push_back(a);
        exp_addr.push_back(a + 16'h0001);
        ea = 16'h3456;
      end
      default:
      begin
        put(a, 8'h10);
        exp_addr.push_back(a);
        exp_addr.push_back(16'hffff);
        ea = (md == 3 ? x_i : y_i) + 16'h0010;
      end
    endcase
    put(ea, m[15:8]);
    put(ea + 16'h0001, m[7:0]);
    exp_addr.push_back(ea);
    exp_addr.push_back(ea + 16'h0001);
    exp_addr.push_back(16'hffff);
    d = r - m;
    fx = {ccr_i[7:4], d[15], d == 16'h0000, (r[15] ^ m[15]) & (d[15] ^ r[15]), m > r};
    pc_i = op;
    start_i = 1'b1;
    foreach (exp_addr[i])
    begin
      @(negedge clk_i);
      `CHK(addr_o, exp_addr[i], "bus address")
      `CHK(rnw_o, 1'b1, "bus direction")
      `CHK(done_o, 1'(i == exp_addr.size() - 1), "done cycle")
      if (i == exp_addr.size() - 1)
        `CHK(ccr_o, fx, "flags")
      @(posedge clk_i);
      #5;
      // the last step leaves start alone so the next scenario may raise it in this step
      if (i + 1 < exp_addr.size())
        start_i = hold_start && (i + 2 < exp_addr.size());
    end
    `CHK(busy_o, 1'b0, "idle after done")
  endtask
  task automatic t_reset;
    `CHK({busy_o, done_o, illegal_o, ccr_o}, 11'h000, "reset outputs")
    `CHK(addr_o, pc_i, "idle address")
  endtask
  // every opcode of both compares, back to back
  task automatic t_all_modes;
    for (int k = 0; k < 10; k++)
      run_cmp(1'(k / 5), k % 5, 16'h4321 + 16'(k), 16'h1200, 1'b0);
  endtask
  // sign, zero, overflow and borrow corners
  task automatic t_flag_corners;
    logic [31:0] tbl [5] = '{32'h7fff_ffff, 32'h8000_0001, 32'h0000_0001, 32'h1234_1234,
      32'hffff_0000};
    foreach (tbl[i])
      run_cmp(1'(i % 2), i % 2 ? 0 : 2, tbl[i][31:16], tbl[i][15:0], 1'b0);
  endtask
  // a start held high while busy must be ignored
  task automatic t_busy_refused;
    run_cmp(1'b0, 3, 16'h0a0a, 16'h0b0b, 1'b1);
  endtask
  // undecodable bytes pulse illegal once and leave flags alone
  task automatic t_illegal(input logic pre, input int want);
    logic [7:0] keep;
    int hits, at;
    keep = ccr_o;
    hits = 0;
    at = 0;
    put(16'h2000, pre ? 8'h1a : 8'h01);
    put(16'h2001, 8'h01);
    start_i = 1'b1;
    for (int k = 1; k <= 4; k++)
    begin
      @(negedge clk_i);
      if (illegal_o === 1'b1)
      begin
        hits++;
        at = k;
      end
      @(posedge clk_i);
      #5;
      // lowered once after the taking edge; later steps leave it for the next scenario
      if (k == 1)
        start_i = 1'b0;
    end
    `CHK(hits, 1, "illegal pulse count")
    `CHK(at, want, "illegal pulse cycle")
    `CHK(ccr_o, keep, "flags kept on illegal")
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole run needs a little over a hundred cycles
  initial
  begin
    #(5000 * 50);
    err_total++;
    close_out();
  end
  // main sequence
  initial
  begin
    err_total = 0;
    num_checks = 0;
    {nrst_i, start_i, pc_i, acc_i, x_i, y_i, ccr_i} = '0;
    repeat (3) @(posedge clk_i);
    #5;
    t_reset();
    nrst_i = 1'b1;
    t_all_modes();
    t_flag_corners();
    t_busy_refused();
    t_illegal(1'b0, 2);
    t_illegal(1'b1, 3);
    close_out();
  end
endmodule
